// ===== logic/rtc_pkg.sv
package rtc_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int          CLK_PERIOD_NS = 50;
  localparam int          RST_HOLD_NS   = 210_000_000;
  localparam logic [22:0] RST_HOLD_CYC  = 23'(RST_HOLD_NS / CLK_PERIOD_NS);
  // Oscillator considered dead after this long without an edge
  localparam int          OSC_FAIL_NS   = 100_000;
  localparam logic [11:0] OSC_FAIL_CYC  = 12'(OSC_FAIL_NS / CLK_PERIOD_NS);
  localparam logic [15:0] OSC_HZ        = 16'h8000;
  localparam logic [15:0] HUND_PER_SEC  = 16'h0064;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [4:0] A_FRAC    = 5'h00;
  localparam logic [4:0] A_SEC     = 5'h01;
  localparam logic [4:0] A_MIN     = 5'h02;
  localparam logic [4:0] A_HOUR    = 5'h03;
  localparam logic [4:0] A_DOW     = 5'h04;
  localparam logic [4:0] A_DATE    = 5'h05;
  localparam logic [4:0] A_MONTH   = 5'h06;
  localparam logic [4:0] A_YEAR    = 5'h07;
  localparam logic [4:0] A_CLK_END = 5'h08;
  localparam logic [4:0] A_WDOG    = 5'h09;
  localparam logic [4:0] A_FREEZE  = 5'h0c;
  localparam logic [4:0] A_FLAGS   = 5'h0f;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int OSC_HALT_BIT    = 7;
  localparam int CENTURY_LO_BIT  = 6;
  localparam int CENTURY_HI_BIT  = 7;
  localparam int OSC_FAIL_IRQ_EN_BIT        = 7;
  localparam int FREEZE_BIT      = 6;
  localparam int OF_BIT          = 2;
  localparam logic [63:0] CLK_RST = 64'h0001_0101_0000_0000;
  localparam logic [7:0]  REG_RST = 8'h00;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef logic [7:0][7:0] rtc_tbytes_t;

  typedef enum logic [2:0] {
    SP_WAIT_HI,
    SP_IDLE,
    SP_HDR,
    SP_WR,
    SP_FETCH,
    SP_LOAD,
    SP_RD
  } rtc_spi_e;

  typedef struct packed {
    logic       we;
    logic [4:0] waddr;
    logic [7:0] wdata;
  } rtc_mem_req_s;

endpackage

// ===== logic/rtc_sync.sv
`timescale 1ns/100ps
module rtc_sync #(
  parameter int             W       = 1,
  parameter logic [W-1:0]   RST_VAL = '0
) (
  input  wire logic         sys_clk,
  input  wire logic         rstn,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } rtc_sync_st_s;

  rtc_sync_st_s st_ff;
  rtc_sync_st_s nxt_st;

  // First stage feeds only the second stage
  always_comb begin
    nxt_st.s1 = din;
    nxt_st.s2 = st_ff.s1;
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      st_ff <= {RST_VAL, RST_VAL};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign dout = st_ff.s2;

endmodule

// ===== logic/rtc_regmem.sv
`timescale 1ns/100ps
module rtc_regmem #(
  parameter int AW = 5,
  parameter int DW = 8
) (
  input  wire logic                 sys_clk,
  input  wire logic                 rstn,
  input  rtc_pkg::rtc_mem_req_s     req,
  input  wire logic [AW-1:0]        raddr,
  output logic      [DW-1:0]        rdata
);

  typedef struct packed {
    logic [(1<<AW)-1:0][DW-1:0] mem;
    logic [DW-1:0]              rd;
  } rtc_mem_st_s;

  rtc_mem_st_s st_ff;
  rtc_mem_st_s nxt_st;

  always_comb begin
    nxt_st    = st_ff;
    nxt_st.rd = st_ff.mem[raddr];
    if (req.we) begin
      nxt_st.mem[req.waddr] = req.wdata;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign rdata = st_ff.rd;

endmodule

// ===== logic/rtc_access_port.sv
// Behaviour
// - Modes 0 and 3 only: sample input on rising, shift output on falling edge.
// - One serial clock per bit; header and data move in eight-bit groups.
// - Address bit 6 is ignored when decoding a register.
// - Header, address and data travel most significant bit first both ways.
// - First bit after select: 1 means writes, 0 means reads.
// - Bits two to eight form the seven-bit start address.
// - Pointer increments after each data byte; raising select ends the transfer.
// - Pointer wraps from 3Fh back to 00h.
// - Clock copy to user registers pauses while address is 00h-07h.
// - Below supply threshold serial inputs are ignored and writes blocked.
// - Reset output low on supply fail and held 210ms after return.
// - Reset hold affects only the reset pin, not access or timekeeping.
// - Timekeeping derives from the 32.768kHz oscillator.
// - Eight BCD clock registers: fraction, seconds, minutes, hours first.
// - Stop bit in 01h D7 halts oscillator; clearing restarts it.
// - Century bits in 03h D7:D6, weekday in 04h, date/month/year after.
// - Oscillator-fail enable in 09h D7 routes the fail flag to interrupt.
// - Any clock register write reloads system clock and resets divider.
// - Power failure sets freeze bit, halting user updates until cleared.
// - Deselected output is high impedance; needs select fall after power-on.
// - Read output stays released until a full byte is ready.
// - Supply fail aborts the access and clears the address pointer.
`timescale 1ns/100ps
module rtc_access_port #(
  parameter logic [22:0] RST_HOLD_CYC = rtc_pkg::RST_HOLD_CYC
) (
  input  wire logic sys_clk,
  input  wire logic rstn,
  input  wire logic osc_32k,
  input  wire logic supply_ok,
  input  wire logic cs_n,
  input  wire logic sclk,
  input  wire logic serial_in,
  output logic      serial_out,
  output logic      serial_out_oe,
  output logic      irq_out,
  output logic      irq_oe,
  output logic      rst_pin_out,
  output logic      rst_pin_oe
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    rtc_pkg::rtc_spi_e    state;
    logic                 sclk_q;
    logic                 supply_q;
    logic                 osc_q;
    logic [2:0]           bitcnt;
    logic [7:0]           sr_in;
    logic [5:0]           ptr;
    logic [7:0]           sr_out;
    logic                 so;
    logic                 so_oe;
    rtc_pkg::rtc_tbytes_t sys;
    rtc_pkg::rtc_tbytes_t usr;
    logic [15:0]          acc;
    logic [11:0]          osc_idle;
    logic                 of;
    logic                 osc_fail_irq_en;
    logic                 ht;
    logic [22:0]          hold;
    logic                 rst_oe;
    logic                 irq_oe;
  } rtc_port_st_s;

  rtc_port_st_s          st_ff;
  rtc_port_st_s          nxt_st;
  rtc_pkg::rtc_mem_req_s mreq;
  logic [7:0]            mem_rdata;
  logic [4:0]            pins_sync;
  logic                  s_osc;
  logic                  s_supply;
  logic                  s_cs_n;
  logic                  s_sclk;
  logic                  s_sdi;

  // ----------------------------------------------------------------
  // Pin synchronisers and register storage
  // ----------------------------------------------------------------
  rtc_sync #(
    .W       (5),
    .RST_VAL (5'h04)
  ) u_sync (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .din     ({osc_32k, supply_ok, cs_n, sclk, serial_in}),
    .dout    (pins_sync)
  );

  assign s_osc    = pins_sync[4];
  assign s_supply = pins_sync[3];
  assign s_cs_n   = pins_sync[2];
  assign s_sclk   = pins_sync[1];
  assign s_sdi    = pins_sync[0];

  rtc_regmem #(
    .AW (5),
    .DW (8)
  ) u_mem (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .req     (mreq),
    .raddr   (st_ff.ptr[4:0]),
    .rdata   (mem_rdata)
  );

  // ----------------------------------------------------------------
  // Calendar helpers
  // ----------------------------------------------------------------
  function automatic logic [8:0] bcd_inc(input logic [7:0] v, input logic [7:0] first,
                                         input logic [7:0] last);
    logic [7:0] r;
    r = 8'h00;
    if (v == last) begin
      return {1'b1, first};
    end
    if (v[3:0] == 4'h9) begin
      r = {v[7:4] + 4'h1, 4'h0};
    end else begin
      r = {v[7:4], v[3:0] + 4'h1};
    end
    return {1'b0, r};
  endfunction

  function automatic logic [7:0] month_last(input logic [7:0] mon, input logic [7:0] yr);
    logic leap;
    leap = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6)
                 : (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8);
    case (mon)
      8'h02:                      return leap ? 8'h29 : 8'h28;
      8'h04, 8'h06, 8'h09, 8'h11: return 8'h30;
      default:                    return 8'h31;
    endcase
  endfunction

  // One hundredth-second step through the BCD calendar
  function automatic rtc_pkg::rtc_tbytes_t tick(input rtc_pkg::rtc_tbytes_t t);
    rtc_pkg::rtc_tbytes_t n;
    logic [8:0]           c;
    logic [1:0]           cen;
    logic [7:0]           hr;
    n   = t;
    cen = {t[rtc_pkg::A_HOUR[2:0]][rtc_pkg::CENTURY_HI_BIT], t[rtc_pkg::A_HOUR[2:0]][rtc_pkg::CENTURY_LO_BIT]};
    c   = bcd_inc(t[rtc_pkg::A_FRAC[2:0]], 8'h00, 8'h99);
    n[rtc_pkg::A_FRAC[2:0]] = c[7:0];
    if (c[8]) begin
      c = bcd_inc({1'b0, t[rtc_pkg::A_SEC[2:0]][6:0]}, 8'h00, 8'h59);
      n[rtc_pkg::A_SEC[2:0]] = {t[rtc_pkg::A_SEC[2:0]][rtc_pkg::OSC_HALT_BIT], c[6:0]};
      if (c[8]) begin
        c = bcd_inc({1'b0, t[rtc_pkg::A_MIN[2:0]][6:0]}, 8'h00, 8'h59);
        n[rtc_pkg::A_MIN[2:0]] = {1'b0, c[6:0]};
        if (c[8]) begin
          c  = bcd_inc({2'b00, t[rtc_pkg::A_HOUR[2:0]][5:0]}, 8'h00, 8'h23);
          hr = c[7:0];
          if (c[8]) begin
            n[rtc_pkg::A_DOW[2:0]] = (t[rtc_pkg::A_DOW[2:0]][2:0] == 3'h7) ? 8'h01
                                   : {5'h00, t[rtc_pkg::A_DOW[2:0]][2:0] + 3'h1};
            c = bcd_inc({2'b00, t[rtc_pkg::A_DATE[2:0]][5:0]}, 8'h01,
                        month_last(t[rtc_pkg::A_MONTH[2:0]], t[rtc_pkg::A_YEAR[2:0]]));
            n[rtc_pkg::A_DATE[2:0]] = c[7:0];
            if (c[8]) begin
              c = bcd_inc({3'b000, t[rtc_pkg::A_MONTH[2:0]][4:0]}, 8'h01, 8'h12);
              n[rtc_pkg::A_MONTH[2:0]] = c[7:0];
              if (c[8]) begin
                c = bcd_inc(t[rtc_pkg::A_YEAR[2:0]], 8'h00, 8'h99);
                n[rtc_pkg::A_YEAR[2:0]] = c[7:0];
                if (c[8]) begin
                  cen = cen + 2'h1;
                end
              end
            end
          end
          n[rtc_pkg::A_HOUR[2:0]] = {cen, hr[5:0]};
        end
      end
    end
    return n;
  endfunction

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic       sclk_rise;
    logic       sclk_fall;
    logic       osc_edge;
    logic       clk_addr;
    logic [7:0] byte_in;
    logic [7:0] rd_byte;
    logic [16:0] acc_sum;
    sclk_rise = 1'b0;
    sclk_fall = 1'b0;
    osc_edge  = 1'b0;
    clk_addr  = 1'b0;
    byte_in   = 8'h00;
    rd_byte   = 8'h00;
    acc_sum   = 17'h00000;
    nxt_st    = st_ff;
    mreq      = '0;

    sclk_rise = s_sclk & ~st_ff.sclk_q;
    sclk_fall = ~s_sclk & st_ff.sclk_q;
    // A stopped oscillator gives no edges, which also feeds fail detection
    osc_edge  = s_osc & ~st_ff.osc_q & ~st_ff.sys[rtc_pkg::A_SEC[2:0]][rtc_pkg::OSC_HALT_BIT];
    clk_addr  = st_ff.ptr[4:0] < rtc_pkg::A_CLK_END;
    byte_in   = {st_ff.sr_in[6:0], s_sdi};
    nxt_st.sclk_q   = s_sclk;
    nxt_st.osc_q    = s_osc;
    nxt_st.supply_q = s_supply;

    // Divider: 100 hundredths per 32768 oscillator edges, error spread evenly
    if (osc_edge) begin
      acc_sum = {1'b0, st_ff.acc} + {1'b0, rtc_pkg::HUND_PER_SEC};
      if (acc_sum >= {1'b0, rtc_pkg::OSC_HZ}) begin
        nxt_st.acc = 16'(acc_sum - {1'b0, rtc_pkg::OSC_HZ});
        nxt_st.sys = tick(st_ff.sys);
      end else begin
        nxt_st.acc = acc_sum[15:0];
      end
    end

    if (osc_edge) begin
      nxt_st.osc_idle = 12'h000;
    end else if (st_ff.osc_idle != rtc_pkg::OSC_FAIL_CYC) begin
      nxt_st.osc_idle = st_ff.osc_idle + 12'h001;
    end

    // User copy follows system copy unless accessed or frozen
    if (!(st_ff.state inside {rtc_pkg::SP_WR, rtc_pkg::SP_FETCH, rtc_pkg::SP_LOAD, rtc_pkg::SP_RD}
          && clk_addr) && !st_ff.ht) begin
      nxt_st.usr = st_ff.sys;
    end

    // Reset pin hold; access itself is never gated by it
    if (!s_supply) begin
      nxt_st.hold   = 23'h000000;
      nxt_st.rst_oe = 1'b1;
    end else if (st_ff.hold != RST_HOLD_CYC) begin
      nxt_st.hold   = st_ff.hold + 23'h000001;
      nxt_st.rst_oe = 1'b1;
    end else begin
      nxt_st.rst_oe = 1'b0;
    end

    // Serial port
    if (!s_supply) begin
      nxt_st.state  = rtc_pkg::SP_WAIT_HI;
      nxt_st.ptr    = 6'h00;
      nxt_st.bitcnt = 3'h0;
      nxt_st.so_oe  = 1'b0;
    end else if (s_cs_n) begin
      nxt_st.state  = rtc_pkg::SP_IDLE;
      nxt_st.bitcnt = 3'h0;
      nxt_st.so_oe  = 1'b0;
    end else begin
      unique case (st_ff.state)
        rtc_pkg::SP_WAIT_HI: begin
          // Select was already low: wait for a real falling edge
          nxt_st.state = rtc_pkg::SP_WAIT_HI;
        end
        rtc_pkg::SP_IDLE: begin
          nxt_st.state  = rtc_pkg::SP_HDR;
          nxt_st.bitcnt = 3'h0;
        end
        rtc_pkg::SP_HDR: begin
          if (sclk_rise) begin
            nxt_st.sr_in  = byte_in;
            nxt_st.bitcnt = st_ff.bitcnt + 3'h1;
            if (st_ff.bitcnt == 3'h7) begin
              nxt_st.ptr   = byte_in[5:0];
              nxt_st.state = byte_in[7] ? rtc_pkg::SP_WR : rtc_pkg::SP_FETCH;
            end
          end
        end
        rtc_pkg::SP_WR: begin
          if (sclk_rise) begin
            nxt_st.sr_in  = byte_in;
            nxt_st.bitcnt = st_ff.bitcnt + 3'h1;
            if (st_ff.bitcnt == 3'h7) begin
              nxt_st.ptr = st_ff.ptr + 6'h01;
              if (clk_addr) begin
                nxt_st.usr[st_ff.ptr[2:0]] = byte_in;
                nxt_st.sys = st_ff.usr;
                nxt_st.sys[st_ff.ptr[2:0]] = byte_in;
                nxt_st.acc = 16'h0000;
              end else begin
                mreq.we    = 1'b1;
                mreq.waddr = st_ff.ptr[4:0];
                mreq.wdata = byte_in;
                if (st_ff.ptr[4:0] == rtc_pkg::A_WDOG) begin
                  nxt_st.osc_fail_irq_en = byte_in[rtc_pkg::OSC_FAIL_IRQ_EN_BIT];
                end
                if (st_ff.ptr[4:0] == rtc_pkg::A_FREEZE) begin
                  nxt_st.ht = byte_in[rtc_pkg::FREEZE_BIT];
                end
                if (st_ff.ptr[4:0] == rtc_pkg::A_FLAGS) begin
                  nxt_st.of = byte_in[rtc_pkg::OF_BIT];
                end
              end
            end
          end
        end
        rtc_pkg::SP_FETCH: begin
          nxt_st.state = rtc_pkg::SP_LOAD;
        end
        rtc_pkg::SP_LOAD: begin
          rd_byte = mem_rdata;
          if (clk_addr) begin
            rd_byte = st_ff.usr[st_ff.ptr[2:0]];
          end else if (st_ff.ptr[4:0] == rtc_pkg::A_FREEZE) begin
            rd_byte[rtc_pkg::FREEZE_BIT] = st_ff.ht;
          end else if (st_ff.ptr[4:0] == rtc_pkg::A_FLAGS) begin
            rd_byte[rtc_pkg::OF_BIT] = st_ff.of;
          end
          nxt_st.sr_out = rd_byte;
          nxt_st.ptr    = st_ff.ptr + 6'h01;
          nxt_st.state  = rtc_pkg::SP_RD;
        end
        rtc_pkg::SP_RD: begin
          if (sclk_fall) begin
            nxt_st.so     = st_ff.sr_out[7];
            nxt_st.sr_out = {st_ff.sr_out[6:0], 1'b0};
            nxt_st.so_oe  = 1'b1;
          end
          if (sclk_rise) begin
            nxt_st.bitcnt = st_ff.bitcnt + 3'h1;
            if (st_ff.bitcnt == 3'h7) begin
              nxt_st.state = rtc_pkg::SP_FETCH;
            end
          end
        end
      endcase
    end

    // Hardware events win over a same-cycle software clear
    if (st_ff.supply_q && !s_supply) begin
      nxt_st.ht = 1'b1;
    end
    if (st_ff.osc_idle == rtc_pkg::OSC_FAIL_CYC) begin
      nxt_st.of = 1'b1;
    end
    nxt_st.irq_oe = nxt_st.of & nxt_st.osc_fail_irq_en;
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      st_ff       <= '0;
      st_ff.state <= rtc_pkg::SP_WAIT_HI;
      st_ff.sys   <= rtc_pkg::CLK_RST;
      st_ff.usr   <= rtc_pkg::CLK_RST;
      st_ff.rst_oe <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign serial_out    = st_ff.so;
  assign serial_out_oe = st_ff.so_oe;
  assign irq_out       = 1'b0;
  assign irq_oe        = st_ff.irq_oe;
  assign rst_pin_out   = 1'b0;
  assign rst_pin_oe    = st_ff.rst_oe;

endmodule

// ===== testbench/rtc_master_model.sv
`timescale 1ns/100ps
module rtc_master_model (
  input  wire logic sys_clk,
  input  wire logic serial_out,
  input  wire logic serial_out_oe,
  output logic      cs_n,
  output logic      sclk,
  output logic      serial_in
);
  logic toggle;
  logic so_line;

  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    serial_in = 1'b0;
    toggle = 1'b0;
  end

  // Released line moves every cycle so a stale bit can never pass
  always @(posedge sys_clk) toggle <= ~toggle;
  assign so_line = serial_out_oe ? serial_out : toggle;

  task automatic gap(input int n);
    repeat (n) @(posedge sys_clk);
    #5;
  endtask

  task automatic sel(input logic lvl);
    gap(6);
    cs_n = lvl;
    gap(6);
  endtask

  // Clock idles low; data set while low, taken on the rise
  task automatic xbyte(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      serial_in = tx[i];
      gap(6);
      rx[i] = so_line;
      sclk = 1'b1;
      gap(6);
      sclk = 1'b0;
    end
  endtask
endmodule

// ===== testbench/rtc_access_port_sva.sv
`timescale 1ns/100ps
module rtc_access_port_sva #(
  parameter logic [22:0] RST_HOLD_CYC = rtc_pkg::RST_HOLD_CYC
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic osc_32k,
  input wire logic supply_ok,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic serial_in,
  input wire logic serial_out,
  input wire logic serial_out_oe,
  input wire logic irq_out,
  input wire logic irq_oe,
  input wire logic rst_pin_out,
  input wire logic rst_pin_oe
);
  logic [23:0] hold_cnt;
  logic [11:0] idle_cnt;
  logic [3:0]  rise_cnt;
  logic        dir_ff;
  logic        sclk_ff;
  logic        osc_ff;

  always_ff @(posedge sys_clk) begin
    sclk_ff <= sclk;
    osc_ff <= osc_32k;
    hold_cnt <= (!rstn || !supply_ok) ? 24'h000000 : hold_cnt + 24'(hold_cnt != 24'hffffff);
    idle_cnt <= (!rstn || (osc_32k && !osc_ff)) ? 12'h000 : idle_cnt + 12'(idle_cnt != 12'hfff);
    if (cs_n) begin
      rise_cnt <= 4'h0;
    end else if (sclk && !sclk_ff && rise_cnt != 4'hf) begin
      rise_cnt <= rise_cnt + 4'h1;
      if (rise_cnt == 4'h0) dir_ff <= serial_in;
    end
  end

  // ------------------------------------------------
  // Checks
  // ------------------------------------------------
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  a_desel_hiz: assert property (cs_n [*5] |-> !serial_out_oe)
    else $error("serial_out driven while deselected");
  a_fail_hiz: assert property (!supply_ok [*5] |-> !serial_out_oe)
    else $error("serial_out driven during supply fail");
  a_oe_after_hdr: assert property ($rose(serial_out_oe) |-> rise_cnt >= 4'h8 && !dir_ff && !cs_n)
    else $error("serial_out enabled before a read byte was ready");
  a_so_on_fall: assert property (serial_out_oe && $past(serial_out_oe) && $changed(serial_out) |-> !sclk)
    else $error("serial_out changed while sclk high");
  a_rst_on_fail: assert property (!supply_ok [*5] |-> rst_pin_oe)
    else $error("reset pin released during supply fail");
  a_rst_hold: assert property (supply_ok && hold_cnt < 24'(RST_HOLD_CYC) |-> rst_pin_oe)
    else $error("reset pin released before hold time");
  a_rst_release: assert property (hold_cnt == 24'(RST_HOLD_CYC) + 24'd6 |-> !rst_pin_oe)
    else $error("reset pin held past hold time");
  a_irq_cause: assert property ($rose(irq_oe) |-> idle_cnt >= 12'd2000 || !cs_n)
    else $error("interrupt raised without oscillator fail");
  a_od_data_low: assert property (irq_out == 1'b0 && rst_pin_out == 1'b0)
    else $error("open drain data not low");
endmodule

// ===== testbench/tb_rtc_access_port.sv
`timescale 1ns/100ps
module tb_rtc_access_port;
  localparam logic [22:0] HOLD = 23'h000014;
  typedef struct packed {
    logic [6:0] wa;
    logic [7:0] wd;
    logic [6:0] ra;
    logic [7:0] exp;
  } rtc_row_s;

  logic       sys_clk;
  logic       rstn;
  logic       osc_32k;
  logic       osc_run;
  logic       supply_ok;
  logic       cs_n;
  logic       sclk;
  logic       serial_in;
  logic       serial_out;
  logic       serial_out_oe;
  logic       irq_out;
  logic       irq_oe;
  logic       rst_pin_out;
  logic       rst_pin_oe;
  logic [7:0] got;
  int         error_cnt = 0;
  int         tests_run = 0;
  logic [7:0] burst [3] = '{8'h55, 8'h99, 8'h05};
  rtc_row_s   rows [7] = '{
    '{7'h1a, 8'h3c, 7'h1a, 8'h3c},
    '{7'h5b, 8'hc1, 7'h1b, 8'hc1},
    '{7'h1c, 8'h96, 7'h5c, 8'h96},
    '{7'h09, 8'h80, 7'h09, 8'h80},
    '{7'h03, 8'hc5, 7'h03, 8'hc5},
    '{7'h04, 8'h05, 7'h04, 8'h05},
    '{7'h07, 8'h42, 7'h07, 8'h42}
  };

  rtc_access_port #(.RST_HOLD_CYC(HOLD)) dut (
    .sys_clk       (sys_clk),
    .rstn          (rstn),
    .osc_32k       (osc_32k),
    .supply_ok     (supply_ok),
    .cs_n          (cs_n),
    .sclk          (sclk),
    .serial_in     (serial_in),
    .serial_out    (serial_out),
    .serial_out_oe (serial_out_oe),
    .irq_out       (irq_out),
    .irq_oe        (irq_oe),
    .rst_pin_out   (rst_pin_out),
    .rst_pin_oe    (rst_pin_oe)
  );

  rtc_master_model m (
    .sys_clk       (sys_clk),
    .serial_out    (serial_out),
    .serial_out_oe (serial_out_oe),
    .cs_n          (cs_n),
    .sclk          (sclk),
    .serial_in     (serial_in)
  );

  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  initial begin
    osc_32k = 1'b0;
    forever begin
      // Time base runs fast so a hundredth ticks within about 1300 cycles
      repeat (2) @(posedge sys_clk);
      #5;
      if (osc_run) osc_32k = ~osc_32k;
    end
  end

  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] seen);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] rx;
    m.sel(1'b0);
    m.xbyte({1'b1, a}, rx);
    m.xbyte(d, rx);
    m.sel(1'b1);
  endtask

  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    logic [7:0] rx;
    m.sel(1'b0);
    m.xbyte({1'b0, a}, rx);
    m.xbyte(8'h00, d);
    m.sel(1'b1);
  endtask

  task automatic end_of_test();
    $display("Checks %0d, mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (30000) @(posedge sys_clk);
    error_cnt++;
    $display("BAD watchdog expected done seen hang");
    end_of_test();
  end

  initial begin
    rstn = 1'b0;
    supply_ok = 1'b1;
    osc_run = 1'b1;
    repeat (2) @(posedge sys_clk);
    #5;
    rstn = 1'b1;
    chk("rst_pin_oe", 8'h01, {7'h00, rst_pin_oe});
    rd(7'h04, got);
    chk("dow reset", 8'h01, got);
    rd(7'h09, got);
    chk("irq_en reset", 8'h00, got);
    chk("rst_pin_oe", 8'h00, {7'h00, rst_pin_oe});
    wr(7'h01, 8'h80);
    wr(7'h01, 8'h00);
    rd(7'h01, got);
    chk("stop clr", 8'h00, got);
    foreach (rows[i]) begin
      wr(rows[i].wa, rows[i].wd);
      rd(rows[i].ra, got);
      chk("row", rows[i].exp, got);
    end
    // ----------------------------------------
    // Burst through the wrap point
    // ----------------------------------------
    m.sel(1'b0);
    m.xbyte(8'hbf, got);
    foreach (burst[i]) m.xbyte(burst[i], got);
    m.sel(1'b1);
    m.sel(1'b0);
    m.xbyte(8'h3f, got);
    foreach (burst[i]) begin
      m.xbyte(8'h00, got);
      chk("burst", burst[i], got);
      // Time ticks here while the copy of 00h-07h stays frozen
      if (i == 0) m.gap(1300);
    end
    m.sel(1'b1);
    rd(7'h01, got);
    chk("copy resumed", 8'h06, got);
    // Stop bit set with hundredths at 99: no carry may reach seconds
    m.sel(1'b0);
    m.xbyte(8'h80, got);
    m.xbyte(8'h99, got);
    m.xbyte(8'h80, got);
    m.sel(1'b1);
    m.gap(1300);
    rd(7'h01, got);
    chk("stop holds", 8'h80, got);
    wr(7'h01, 8'h00);
    // Stopped time base must raise the enabled interrupt
    osc_run = 1'b0;
    m.gap(2100);
    chk("irq_oe on", 8'h01, {7'h00, irq_oe});
    wr(7'h09, 8'h00);
    chk("irq_oe off", 8'h00, {7'h00, irq_oe});
    osc_run = 1'b1;
    // ----------------------------------------
    // Supply loss in mid write
    // ----------------------------------------
    m.sel(1'b0);
    m.xbyte(8'h9a, got);
    supply_ok = 1'b0;
    m.xbyte(8'hee, got);
    m.sel(1'b1);
    chk("rst_pin_oe fail", 8'h01, {7'h00, rst_pin_oe});
    supply_ok = 1'b1;
    m.gap(4);
    chk("rst_pin_oe hold", 8'h01, {7'h00, rst_pin_oe});
    rd(7'h0c, got);
    chk("freeze", 8'h40, got);
    rd(7'h1a, got);
    chk("blocked", 8'h3c, got);
    wr(7'h0c, 8'h00);
    rd(7'h0c, got);
    chk("freeze clr", 8'h00, got);
    chk("rst_pin_oe end", 8'h00, {7'h00, rst_pin_oe});
    end_of_test();
  end
endmodule

bind rtc_access_port rtc_access_port_sva #(.RST_HOLD_CYC(RST_HOLD_CYC)) u_sva (
  .sys_clk       (sys_clk),
  .rstn          (rstn),
  .osc_32k       (osc_32k),
  .supply_ok     (supply_ok),
  .cs_n          (cs_n),
  .sclk          (sclk),
  .serial_in     (serial_in),
  .serial_out    (serial_out),
  .serial_out_oe (serial_out_oe),
  .irq_out       (irq_out),
  .irq_oe        (irq_oe),
  .rst_pin_out   (rst_pin_out),
  .rst_pin_oe    (rst_pin_oe)
);
